/* File: hdl/ovt_pkg.sv */
// constants and carrier types for the over-temperature fault response block
package ovt_pkg;

   // command codes of the management port
   localparam logic [7:0]  CMD_CLEAR_FAULTS   = 8'h03;
   localparam logic [7:0]  CMD_IOUT_WARN_THR  = 8'h4A;
   localparam logic [7:0]  CMD_OT_FAULT_THR   = 8'h4F;
   localparam logic [7:0]  CMD_OT_FAULT_ACT   = 8'h50;
   localparam logic [7:0]  CMD_DELAY_UNIT     = 8'hD2;

   // reset values (plain defaults)
   localparam logic [15:0] RST_IOUT_WARN_THR  = 16'h0000;
   localparam logic [15:0] RST_OT_FAULT_THR   = 16'h0000;
   localparam logic [7:0]  RST_OT_FAULT_ACT   = 8'h00;
   localparam logic [15:0] RST_DELAY_UNIT     = 16'h03E8;

   // field positions of the action register
   localparam int ACT_RESP_HI  = 7;
   localparam int ACT_RESP_LO  = 6;
   localparam int ACT_RETRY_HI = 5;
   localparam int ACT_RETRY_LO = 3;
   localparam int ACT_DELAY_HI = 2;
   localparam int ACT_DELAY_LO = 0;

   // linear format mantissa width
   localparam int LIN_MANT_W = 11;

   // response codes
   localparam logic [1:0] RESP_IGNORE    = 2'h0;
   localparam logic [1:0] RESP_TOLERATE  = 2'h1;
   localparam logic [1:0] RESP_DISABLE   = 2'h2;
   localparam logic [1:0] RESP_LATCH_OFF = 2'h3;

   // retry codes
   localparam logic [2:0] RETRY_NONE     = 3'h0;
   localparam logic [2:0] RETRY_FOREVER  = 3'h7;

   // delay code to unit counts
   localparam logic [7:0] DLY_CNT_0 = 8'h01;
   localparam logic [7:0] DLY_CNT_1 = 8'h02;
   localparam logic [7:0] DLY_CNT_2 = 8'h04;
   localparam logic [7:0] DLY_CNT_3 = 8'h10;
   localparam logic [7:0] DLY_CNT_4 = 8'h08;
   localparam logic [7:0] DLY_CNT_5 = 8'h20;
   localparam logic [7:0] DLY_CNT_6 = 8'h40;
   localparam logic [7:0] DLY_CNT_7 = 8'h80;

   // fault handling states
   typedef enum logic [1:0] {
      OVT_RUN      = 2'b00,
      OVT_TOLERATE = 2'b01,
      OVT_RETRY    = 2'b10,
      OVT_LATCHED  = 2'b11
   } ovt_state_t;

   // one management command, already decoded from the serial link
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [7:0]  code;
      logic [15:0] wdata;
   } ovt_cmd_t;

   // answer to a read command
   typedef struct packed {
      logic        valid;
      logic        err;
      logic [15:0] rdata;
   } ovt_rsp_t;

   function automatic logic [7:0] delay_units(input logic [2:0] code);
      case (code)
         3'h0:    delay_units = DLY_CNT_0;
         3'h1:    delay_units = DLY_CNT_1;
         3'h2:    delay_units = DLY_CNT_2;
         3'h3:    delay_units = DLY_CNT_3;
         3'h4:    delay_units = DLY_CNT_4;
         3'h5:    delay_units = DLY_CNT_5;
         3'h6:    delay_units = DLY_CNT_6;
         default: delay_units = DLY_CNT_7;
      endcase
   endfunction : delay_units

endpackage : ovt_pkg

/* File: hdl/ovt_delay_timer.sv */
// delay timer counting whole delay units of programmable length
module ovt_delay_timer (
   // clock and reset
   input  wire logic        ref_clk_i,
   input  wire logic        rst_i,
   // control
   input  wire logic        start_i,
   input  wire logic        stop_i,
   input  wire logic [7:0]  units_i,
   input  wire logic [15:0] unit_len_i,
   // status
   output logic             busy_o,
   output logic             done_o
);
   import ovt_pkg::*;

   logic [15:0] pre_r,  pre_nxt;
   logic [7:0]  unit_r, unit_nxt;
   logic        busy_r, busy_nxt;
   logic        done_r, done_nxt;

   always_comb begin
      pre_nxt  = pre_r;
      unit_nxt = unit_r;
      busy_nxt = busy_r;
      done_nxt = 1'b0;
      if (stop_i) begin
         busy_nxt = 1'b0;
      end else if (start_i) begin
         pre_nxt  = 16'h0000;
         unit_nxt = units_i;
         busy_nxt = 1'b1;
      end else if (busy_r) begin
         // a unit length of zero is served as one cycle
         if (pre_r + 16'h0001 >= unit_len_i) begin
            pre_nxt  = 16'h0000;
            unit_nxt = unit_r - 8'h01;
            if (unit_r <= 8'h01) begin
               busy_nxt = 1'b0;
               done_nxt = 1'b1;
            end
         end else begin
            pre_nxt = pre_r + 16'h0001;
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         pre_r  <= 16'h0000;
         unit_r <= 8'h00;
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         pre_r  <= pre_nxt;
         unit_r <= unit_nxt;
         busy_r <= busy_nxt;
         done_r <= done_nxt;
      end
   end

   assign busy_o = busy_r;
   assign done_o = done_r;

endmodule : ovt_delay_timer

/* File: hdl/ovt_fault_response.sv */
// over-temperature fault response with threshold and action registers
//
// Notes on behaviour
// - a 16-bit linear-format output current warning threshold sits at 0x4A.
// - a 16-bit linear-format over-temperature threshold sits at 0x4F.
// - action register at 0x50, response 00 keeps the output running.
// - response 01 runs on for the delay, then acts on the retry field.
// - response 10 turns the output off at once, then acts on the retry field.
// - response 11 turns the output off until a clearing event.
// - status bit clear or clear-faults command clear it once the fault is gone; reset and power loss clear it.
// - commanding the output off and then on again also clears the latch.
// - retry code 000 makes no restart and holds the output off.
// - retry code 001 makes exactly one restart attempt.
// - when all restart attempts fail the output stays off until cleared.
// - restart attempts start one delay field interval apart.
// - delay codes map to 1, 2, 4, 16, 8, 32, 64 and 128 units.
// - the length of one unit comes from the register at 0xD2.
// - retry codes 100 to 110 allow 4 to 6 attempts, 111 retries forever.
module ovt_fault_response (
   // clock and reset
   input  wire logic          ref_clk_i,
   input  wire logic          rst_i,
   // decoded management commands
   input  ovt_pkg::ovt_cmd_t  cmd_i,
   output ovt_pkg::ovt_rsp_t  rsp_o,
   // monitoring and control
   input  wire logic [15:0]   temp_i,
   input  wire logic          clear_ot_bit_i,
   input  wire logic          out_on_pin_i,
   // output and status
   output logic               out_en_o,
   output logic               ot_fault_o,
   output logic               ot_latched_o,
   output logic [15:0]        iout_warn_thr_o
);
   import ovt_pkg::*;

   // registers
   logic [15:0] iout_thr_r, iout_thr_nxt;
   logic [15:0] ot_thr_r,   ot_thr_nxt;
   logic [7:0]  ot_act_r,   ot_act_nxt;
   logic [15:0] unit_r,     unit_nxt;
   ovt_rsp_t    rsp_r,      rsp_nxt;
   logic        clr_cmd;

   always_comb begin
      iout_thr_nxt = iout_thr_r;
      ot_thr_nxt   = ot_thr_r;
      ot_act_nxt   = ot_act_r;
      unit_nxt     = unit_r;
      rsp_nxt      = '0;
      clr_cmd      = 1'b0;
      if (cmd_i.valid && cmd_i.write) begin
         case (cmd_i.code)
            CMD_IOUT_WARN_THR: iout_thr_nxt = cmd_i.wdata;
            CMD_OT_FAULT_THR:  ot_thr_nxt   = cmd_i.wdata;
            CMD_OT_FAULT_ACT:  ot_act_nxt   = cmd_i.wdata[7:0];
            CMD_DELAY_UNIT:    unit_nxt     = cmd_i.wdata;
            CMD_CLEAR_FAULTS:  clr_cmd      = 1'b1;
            default:           clr_cmd      = 1'b0;
         endcase
      end else if (cmd_i.valid) begin
         rsp_nxt.valid = 1'b1;
         case (cmd_i.code)
            CMD_IOUT_WARN_THR: rsp_nxt.rdata = iout_thr_r;
            CMD_OT_FAULT_THR:  rsp_nxt.rdata = ot_thr_r;
            CMD_OT_FAULT_ACT:  rsp_nxt.rdata = {8'h00, ot_act_r};
            CMD_DELAY_UNIT:    rsp_nxt.rdata = unit_r;
            default:           rsp_nxt.err   = 1'b1;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         iout_thr_r <= RST_IOUT_WARN_THR;
         ot_thr_r   <= RST_OT_FAULT_THR;
         ot_act_r   <= RST_OT_FAULT_ACT;
         unit_r     <= RST_DELAY_UNIT;
         rsp_r      <= '0;
      end else begin
         iout_thr_r <= iout_thr_nxt;
         ot_thr_r   <= ot_thr_nxt;
         ot_act_r   <= ot_act_nxt;
         unit_r     <= unit_nxt;
         rsp_r      <= rsp_nxt;
      end
   end

   // on/off pin: three stages, a change counts when stages two and three agree
   logic [2:0] on_sync_r, on_sync_nxt;
   logic       on_r,      on_nxt;
   logic       on_fell;

   always_comb begin
      on_sync_nxt = {on_sync_r[1:0], out_on_pin_i};
      on_nxt      = on_r;
      if (on_sync_r[1] == on_sync_r[2]) begin
         on_nxt = on_sync_r[2];
      end
      on_fell = on_r && !on_nxt;
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         on_sync_r <= 3'b000;
         on_r      <= 1'b0;
      end else begin
         on_sync_r <= on_sync_nxt;
         on_r      <= on_nxt;
      end
   end

   // signed mantissa of a linear word; both words share one exponent
   function automatic logic signed [LIN_MANT_W-1:0]
      lin_mant(input logic [15:0] w);
      lin_mant = $signed(w[LIN_MANT_W-1:0]);
   endfunction : lin_mant

   logic fault;
   assign fault = lin_mant(temp_i) > lin_mant(ot_thr_r);

   // fault handling state
   ovt_state_t st_r,    st_nxt;
   logic [2:0] tries_r, tries_nxt;
   logic       en_r,    en_nxt;
   logic       flt_r,   flt_nxt;
   logic       lat_r,   lat_nxt;
   logic       tmr_start;
   logic       tmr_stop;
   logic       tmr_done;
   logic [1:0] resp;
   logic [2:0] retry;
   logic [7:0] units;
   logic       clear_any;

   assign resp  = ot_act_r[ACT_RESP_HI:ACT_RESP_LO];
   assign retry = ot_act_r[ACT_RETRY_HI:ACT_RETRY_LO];
   assign units = delay_units(ot_act_r[ACT_DELAY_HI:ACT_DELAY_LO]);

   ovt_delay_timer u_timer (
      .ref_clk_i  (ref_clk_i),
      .rst_i      (rst_i),
      .start_i    (tmr_start),
      .stop_i     (tmr_stop),
      .units_i    (units),
      .unit_len_i (unit_r),
      .busy_o     (),
      .done_o     (tmr_done)
   );

   always_comb begin
      st_nxt    = st_r;
      tries_nxt = tries_r;
      tmr_start = 1'b0;
      tmr_stop  = 1'b0;
      // a fault seen while clearing still wins: the latched state holds below
      flt_nxt   = fault || (flt_r && !clear_ot_bit_i && !clr_cmd);
      clear_any = clear_ot_bit_i || clr_cmd;
      case (st_r)
         OVT_RUN: begin
            tries_nxt = 3'h0;
            if (fault && on_r) begin
               case (resp)
                  RESP_IGNORE:   st_nxt = OVT_RUN;
                  RESP_TOLERATE: begin
                     st_nxt    = OVT_TOLERATE;
                     tmr_start = 1'b1;
                  end
                  RESP_DISABLE: begin
                     if (retry == RETRY_NONE) begin
                        st_nxt = OVT_LATCHED;
                     end else begin
                        st_nxt    = OVT_RETRY;
                        tmr_start = 1'b1;
                     end
                  end
                  default:       st_nxt = OVT_LATCHED;
               endcase
            end
         end
         OVT_TOLERATE: begin
            if (tmr_done) begin
               if (!fault) begin
                  st_nxt = OVT_RUN;
               end else if (retry == RETRY_NONE) begin
                  st_nxt = OVT_LATCHED;
               end else begin
                  st_nxt    = OVT_RETRY;
                  tmr_start = 1'b1;
               end
            end
         end
         OVT_RETRY: begin
            // each expiry is the start of one restart attempt
            if (tmr_done) begin
               if (!fault) begin
                  st_nxt = OVT_RUN;
               end else if (retry != RETRY_FOREVER &&
                            tries_r + 3'h1 >= retry) begin
                  st_nxt = OVT_LATCHED;
               end else begin
                  tries_nxt = tries_r + 3'h1;
                  tmr_start = 1'b1;
               end
            end
         end
         OVT_LATCHED: begin
            if (clear_any && !fault) begin
               st_nxt = OVT_RUN;
            end
         end
         default: st_nxt = OVT_RUN;
      endcase
      // commanding off ends any response; turning on again starts clean
      if (on_fell) begin
         st_nxt    = OVT_RUN;
         tmr_stop  = 1'b1;
         tmr_start = 1'b0;
         tries_nxt = 3'h0;
      end
      en_nxt  = on_nxt && (st_nxt == OVT_RUN || st_nxt == OVT_TOLERATE);
      lat_nxt = st_nxt == OVT_LATCHED;
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         st_r    <= OVT_RUN;
         tries_r <= 3'h0;
         en_r    <= 1'b0;
         flt_r   <= 1'b0;
         lat_r   <= 1'b0;
      end else begin
         st_r    <= st_nxt;
         tries_r <= tries_nxt;
         en_r    <= en_nxt;
         flt_r   <= flt_nxt;
         lat_r   <= lat_nxt;
      end
   end

   assign rsp_o           = rsp_r;
   assign out_en_o        = en_r;
   assign ot_fault_o      = flt_r;
   assign ot_latched_o    = lat_r;
   assign iout_warn_thr_o = iout_thr_r;

endmodule : ovt_fault_response

/* File: dv/ovt_checker.sv */
// port assertions for the over-temperature fault response block
module ovt_checker (
   // clock and reset
   input wire logic        ref_clk_i,
   input wire logic        rst_i,
   // command port
   input ovt_pkg::ovt_cmd_t cmd_i,
   input ovt_pkg::ovt_rsp_t rsp_o,
   // monitoring and status
   input wire logic [15:0] temp_i,
   input wire logic        clear_ot_bit_i,
   input wire logic        out_on_pin_i,
   input wire logic        out_en_o,
   input wire logic        ot_fault_o,
   input wire logic        ot_latched_o,
   input wire logic [15:0] iout_warn_thr_o
);
   import ovt_pkg::*;
   logic [15:0] thr_r, thr_nxt;
   logic [7:0]  act_r, act_nxt;
   logic [2:0]  on_r, on_nxt;
   logic        wr, clr, flt, on_ok;
   assign wr = cmd_i.valid && cmd_i.write;
   assign clr = clear_ot_bit_i || (wr && cmd_i.code == CMD_CLEAR_FAULTS);
   // mantissas only, exponents assumed equal
   assign flt = $signed(temp_i[10:0]) > $signed(thr_r[10:0]);
   // pin must sit high well past the three-flop synchroniser
   assign on_ok = out_on_pin_i && on_r == 3'h7;
   always_comb begin
      thr_nxt = thr_r;
      act_nxt = act_r;
      on_nxt = (on_r == 3'h7) ? on_r : on_r + 3'h1;
      if (wr && cmd_i.code == CMD_OT_FAULT_THR) thr_nxt = cmd_i.wdata;
      if (wr && cmd_i.code == CMD_OT_FAULT_ACT) act_nxt = cmd_i.wdata[7:0];
      if (!out_on_pin_i) on_nxt = 3'h0;
   end
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         thr_r <= RST_OT_FAULT_THR;
         act_r <= RST_OT_FAULT_ACT;
         on_r <= 3'h0;
      end else begin
         thr_r <= thr_nxt;
         act_r <= act_nxt;
         on_r <= on_nxt;
      end
   end
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (rst_i);
   a_warn_thr_load: assert property (
      wr && cmd_i.code == CMD_IOUT_WARN_THR
      |=> iout_warn_thr_o == $past(cmd_i.wdata)) else $error("warn thr");
   a_thr_readback: assert property (
      cmd_i.valid && !cmd_i.write && cmd_i.code == CMD_OT_FAULT_THR
      |=> rsp_o.valid && !rsp_o.err && rsp_o.rdata == thr_r)
      else $error("thr read");
   a_fault_flag: assert property (
      flt && out_en_o && on_ok |=> ot_fault_o) else $error("fault flag");
   a_ignore_runs: assert property (
      act_r[7:6] == RESP_IGNORE && out_en_o && flt && on_ok |=> out_en_o)
      else $error("ignore dropped output");
   a_disable_now: assert property (
      act_r[7] && out_en_o && flt && on_ok |=> !out_en_o)
      else $error("no disable");
   a_latch_off: assert property (
      ot_latched_o |-> !out_en_o) else $error("latched but on");
   a_latch_holds: assert property (
      ot_latched_o && !clr && on_ok |=> ot_latched_o)
      else $error("latch lost");
   a_clear_exits: assert property (
      ot_latched_o && clr && !flt |=> !ot_latched_o)
      else $error("clear ignored");
   a_off_disables: assert property (
      !out_on_pin_i [*6] |-> !out_en_o) else $error("on while off");
   c_latched: cover property ($rose(ot_latched_o));
   c_err_read: cover property (rsp_o.valid && rsp_o.err);
   c_restart: cover property ($rose(out_en_o) && act_r[7:6] == RESP_DISABLE);
endmodule : ovt_checker

bind ovt_fault_response ovt_checker u_chk (.ref_clk_i, .rst_i, .cmd_i,
   .rsp_o, .temp_i, .clear_ot_bit_i, .out_on_pin_i, .out_en_o,
   .ot_fault_o, .ot_latched_o, .iout_warn_thr_o);

/* File: dv/ovt_host_model.sv */
// host model driving management commands and the on/off pin
module ovt_host_model (
   // clock
   input  wire logic         ref_clk_i,
   // towards the block
   output ovt_pkg::ovt_cmd_t cmd_o,
   output logic              on_o
);
   import ovt_pkg::*;
   // expected read answers, err bit on top
   logic [16:0] exp_q[$];
   initial begin
      cmd_o = '0;
      on_o = 1'b0;
   end
   task automatic send(input logic w, input logic [7:0] c,
                       input logic [15:0] d);
      @(posedge ref_clk_i);
      cmd_o <= '{1'b1, w, c, d};
      @(posedge ref_clk_i);
      // idle fields scrambled so nothing stale passes as a command
      cmd_o <= '{1'b0, ~w, ~c, ~d};
   endtask : send
   task automatic rd(input logic [7:0] c, input logic [16:0] e);
      exp_q.push_back(e);
      send(1'b0, c, 16'h0000);
   endtask : rd
   task automatic power_cycle();
      @(posedge ref_clk_i);
      on_o <= 1'b0;
      repeat (6) @(posedge ref_clk_i);
      on_o <= 1'b1;
      repeat (8) @(posedge ref_clk_i);
   endtask : power_cycle
endmodule : ovt_host_model

/* File: dv/ovt_fault_response_tb.sv */
// self-checking bench for the over-temperature fault response block
module ovt_fault_response_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import ovt_pkg::*;
   logic        ref_clk_i, rst_i, clr_bit, on, out_en, flt, lat;
   logic [15:0] temp, warn, v;
   ovt_cmd_t    cmd;
   ovt_rsp_t    rsp;
   int          n_fail = 0, n_checks = 0, cyc = 0, seed;

   ovt_host_model u_host (.ref_clk_i(ref_clk_i), .cmd_o(cmd), .on_o(on));
   ovt_fault_response u_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .cmd_i(cmd), .rsp_o(rsp), .temp_i(temp), .clear_ot_bit_i(clr_bit),
      .out_on_pin_i(on), .out_en_o(out_en), .ot_fault_o(flt),
      .ot_latched_o(lat), .iout_warn_thr_o(warn));

   initial begin
      ref_clk_i = 1'b0;
      forever #50 ref_clk_i = ~ref_clk_i;
   end
   task automatic check(input logic [16:0] got, input logic [16:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : check
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim
   // write the action, run hot for hold cycles, then look at the output
   task automatic step(input logic [7:0] act, input int hold, total,
                       input logic en, lt);
      u_host.send(1'b1, CMD_OT_FAULT_ACT, {8'h00, act});
      for (int i = 0; i < total; i++) begin
         temp <= (i < hold) ? 16'h0020 : 16'h0000;
         @(posedge ref_clk_i);
      end
      #1;
      check({15'h0, out_en, lat}, {15'h0, en, lt});
   endtask : step
   always @(posedge ref_clk_i) begin
      cyc++;
      if (rsp.valid === 1'b1) begin
         if (u_host.exp_q.size() == 0) check(17'h1FFFF, 17'h0);
         else check({rsp.err, rsp.rdata}, u_host.exp_q.pop_front());
      end
      if (cyc == 3000) begin
         n_fail++;
         end_sim();
      end
   end
   initial begin
      seed = 68129;
      rst_i = 1'b1;
      temp = 16'h0000;
      clr_bit = 1'b0;
      repeat (4) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      u_host.rd(CMD_IOUT_WARN_THR, {1'b0, RST_IOUT_WARN_THR});
      u_host.rd(CMD_OT_FAULT_THR, {1'b0, RST_OT_FAULT_THR});
      u_host.rd(CMD_OT_FAULT_ACT, {9'h000, RST_OT_FAULT_ACT});
      u_host.rd(CMD_DELAY_UNIT, {1'b0, RST_DELAY_UNIT});
      u_host.rd(CMD_CLEAR_FAULTS, 17'h10000);
      v = $random(seed);
      u_host.send(1'b1, CMD_IOUT_WARN_THR, v);
      #1 check({1'b0, warn}, {1'b0, v});
      u_host.rd(CMD_IOUT_WARN_THR, {1'b0, v});
      v = $random(seed);
      u_host.send(1'b1, CMD_OT_FAULT_ACT, v);
      u_host.rd(CMD_OT_FAULT_ACT, {9'h000, v[7:0]});
      u_host.send(1'b1, CMD_DELAY_UNIT, 16'h0002);
      u_host.send(1'b1, CMD_OT_FAULT_THR, 16'h0010);
      u_host.rd(CMD_OT_FAULT_THR, 17'h00010);
      u_host.power_cycle();
      step(8'h00, 12, 12, 1'b1, 1'b0);
      check({16'h0, flt}, 17'h1);
      step(8'hC0, 4, 12, 1'b0, 1'b1);
      u_host.send(1'b1, CMD_CLEAR_FAULTS, 16'h0000);
      step(8'hC0, 0, 4, 1'b1, 1'b0);
      check({16'h0, flt}, 17'h0);
      step(8'h80, 4, 12, 1'b0, 1'b1);
      @(posedge ref_clk_i);
      clr_bit <= 1'b1;
      @(posedge ref_clk_i);
      clr_bit <= 1'b0;
      step(8'h80, 0, 4, 1'b1, 1'b0);
      // 16 units of 2 cycles: back too early if the unit count is wrong
      step(8'h8B, 4, 20, 1'b0, 1'b0);
      step(8'h8B, 0, 30, 1'b1, 1'b0);
      step(8'h88, 36, 40, 1'b0, 1'b1);
      u_host.power_cycle();
      step(8'h88, 0, 2, 1'b1, 1'b0);
      step(8'h79, 99, 2, 1'b1, 1'b0);
      step(8'h79, 99, 60, 1'b0, 1'b0);
      step(8'h79, 0, 30, 1'b1, 1'b0);
      // four attempts of 8 units: three expiries pass, the fourth latches
      step(8'hA4, 99, 60, 1'b0, 1'b0);
      step(8'hA4, 99, 20, 1'b0, 1'b1);
      end_sim();
   end
endmodule : ovt_fault_response_tb
